// ---- hdl/rtcd_cfg.svh ----
/*
  Constants for the calendar clock front end: register offsets, field
  positions, reset values, unlock key bytes and trim period figures.
  Assumes it is included by bare name wherever these are needed.
*/
// What this block does
// - prescaler before divider divides reference by 1, 16, 64 or 256.
// - a 16-bit down counter divides prescaled pulses by programmed period plus one.
// - fine trim of zero removes no pulses at all.
// - nonzero trim removes that many pulses in each 16-second span.
// - divider yields half-second and one-second ticks for the calendar.
// - any device reset clears the write lock to zero.
// - while locked, writes to enable, control two, period, time and date are ignored.
// - while locked, other control, alarm and timestamp writes still land.
// - clearing a set lock needs key bytes 55h then AAh first.
// - lock clear must come in the write right after the key pair.
// - lock may be set by a plain write when it is clear.
// - source select: 00 crystal, 01 rc, 10 powerline, 11 system clock.
// - every time, date and alarm register has its own address.
// - each trim step lengthens the divider by one input cycle per span.
`ifndef RTCD_CFG_SVH
`define RTCD_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define RTCD_OFS_CTRL1   8'h00
`define RTCD_OFS_CTRL2   8'h04
`define RTCD_OFS_PERIOD  8'h08
`define RTCD_OFS_KEY     8'h0c
`define RTCD_OFS_STATUS  8'h10
`define RTCD_OFS_TIME    8'h14
`define RTCD_OFS_DATE    8'h18
`define RTCD_OFS_ALARM   8'h1c
`define RTCD_OFS_STAMP   8'h20

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define RTCD_EN_BIT      15
`define RTCD_LOCK_BIT    11
`define RTCD_TRIM_LSB    11
`define RTCD_PS_LSB      4
`define RTCD_SRC_LSB     0
`define RTCD_PERIOD_RST  16'h7fff
`define RTCD_KEY_FIRST   8'h55
`define RTCD_KEY_SECOND  8'haa
`define RTCD_TRIM_SPAN_S 16
`define RTCD_TRIM_SLOTS  (2 * `RTCD_TRIM_SPAN_S)

`endif

// ---- hdl/rtcd_pkg.sv ----
/*
  Types shared by the calendar clock front end modules.
  Assumes rtcd_cfg.svh for the numeric constants.
*/
package rtcd_pkg;

  // reference source codes
  typedef enum logic [1:0] {
    RTCD_SRC_CRYSTAL = 2'h0,
    RTCD_SRC_RC      = 2'h1,
    RTCD_SRC_MAINS   = 2'h2,
    RTCD_SRC_SYSCLK  = 2'h3
  } rtcd_src_t;

  // unlock key progress, gray coded along the path
  typedef enum logic [1:0] {
    RTCD_KEY_IDLE  = 2'h0,
    RTCD_KEY_HALF  = 2'h1,
    RTCD_KEY_ARMED = 2'h3
  } rtcd_key_t;

endpackage

// ---- hdl/rtcd_tick_if.sv ----
/*
  Carrier between the register block, the prescaler and the divider.
  Assumes all three parts run on mclk.
*/
`timescale 1ns/1ps
interface rtcd_tick_if;
  import rtcd_pkg::*;
  rtcd_src_t   source;
  logic [1:0]  prescale;
  logic [4:0]  fine_trim;
  logic [15:0] period;
  logic        run;
  logic        scaled_pulse;
  logic        half_tick;
  logic        sec_tick;
  logic        half_phase;

  modport ctl (output source, prescale, fine_trim, period, run,
               input  half_tick, sec_tick, half_phase);
  modport pre (input source, prescale, run, output scaled_pulse);
  modport div (input fine_trim, period, run, scaled_pulse,
               output half_tick, sec_tick, half_phase);
endinterface

// ---- hdl/rtcd_prescaler.sv ----
/*
  Reference source selection and prescaler.
  Assumes the source inputs are synchronous levels on mclk.
*/
`timescale 1ns/1ps
module rtcd_prescaler
  import rtcd_pkg::*;
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // reference levels
  input  wire logic crystal_in,
  input  wire logic rc_in,
  input  wire logic mains_in,
  // link to divider
  rtcd_tick_if.pre  tk
);
  logic       sel_lvl;
  logic       prev_q;
  logic       ref_edge;
  logic [7:0] cnt_q;
  logic       wrap;

  // source mux; system clock counts every cycle
  always_comb
  begin
    case (tk.source)
      RTCD_SRC_CRYSTAL: sel_lvl = crystal_in;
      RTCD_SRC_RC:      sel_lvl = rc_in;
      RTCD_SRC_MAINS:   sel_lvl = mains_in;
      default:          sel_lvl = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n) prev_q <= 1'b0;
    else        prev_q <= sel_lvl;
  end

  assign ref_edge = (tk.source == RTCD_SRC_SYSCLK) ? 1'b1
                                                   : (sel_lvl & ~prev_q);

  // ratio 1:1, 1:16, 1:64, 1:256 by how many low bits must be ones
  always_comb
  begin
    case (tk.prescale)
      2'h0:    wrap = 1'b1;
      2'h1:    wrap = &cnt_q[3:0];
      2'h2:    wrap = &cnt_q[5:0];
      default: wrap = &cnt_q[7:0];
    endcase
  end

  // counter holds at zero while stopped so a restart has a full period
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q           <= 8'h00;
      tk.scaled_pulse <= 1'b0;
    end
    else
    begin
      tk.scaled_pulse <= tk.run & ref_edge & wrap;
      if (!tk.run)
        cnt_q <= 8'h00;
      else if (ref_edge)
        cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule // rtcd_prescaler

// ---- hdl/rtcd_divider.sv ----
/*
  Coarse 16-bit divider with fractional pulse removal.
  Assumes one prescaled pulse per cycle at most.
*/
`timescale 1ns/1ps
module rtcd_divider
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // link from prescaler and registers
  rtcd_tick_if.div  tk
);
  logic [15:0] cnt_q;
  logic [4:0]  slot_q;
  logic        drop_q;
  logic        keep;
  logic        under;

  // a pending removal swallows the next prescaled pulse
  assign keep  = tk.scaled_pulse & ~drop_q;
  assign under = keep & (cnt_q == 16'h0000);

  // down counter, reload on underflow
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 16'h0000;
    else if (!tk.run)
      cnt_q <= tk.period;
    else if (under)
      cnt_q <= tk.period;
    else if (keep)
      cnt_q <= cnt_q - 16'h0001;
  end

  // ticks and phase
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tk.half_tick  <= 1'b0;
      tk.sec_tick   <= 1'b0;
      tk.half_phase <= 1'b0;
    end
    else
    begin
      tk.half_tick <= under;
      tk.sec_tick  <= under & tk.half_phase;
      if (!tk.run)
        tk.half_phase <= 1'b0;
      else if (under)
        tk.half_phase <= ~tk.half_phase;
    end
  end

  // 32 half-second slots form the 16 s span; slots below trim drop one
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slot_q <= 5'h00;
      drop_q <= 1'b0;
    end
    else if (!tk.run)
    begin
      slot_q <= 5'h00;
      drop_q <= 1'b0;
    end
    else if (under)
    begin
      slot_q <= slot_q + 5'h01;
      drop_q <= (slot_q < tk.fine_trim);
    end
    else if (tk.scaled_pulse)
      drop_q <= 1'b0;
  end
endmodule // rtcd_divider

// ---- hdl/rtcd_top.sv ----
/*
  Calendar clock front end: Avalon-MM register slave, write lock with
  unlock key, and the prescaler and divider that make the time ticks.
  Assumes a single mclk domain and synchronous reference inputs.
*/
`timescale 1ns/1ps
`include "rtcd_cfg.svh"
module rtcd_top
  import rtcd_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // reference sources
  input  wire logic        secondary_crystal_osc,
  input  wire logic        low_power_rc_osc,
  input  wire logic        powerline_in,
  // calendar side
  output logic             half_tick,
  output logic             sec_tick,
  output logic             calendar_clock_enable,
  output logic      [31:0] time_value,
  output logic      [31:0] date_value,
  output logic      [31:0] alarm_value
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        lock_q;
  logic        enable_q;
  logic [10:0] ctrl1_rest_q;
  logic [15:0] ctrl2_q;
  logic [15:0] period_q;
  logic [31:0] time_q;
  logic [31:0] date_q;
  logic [31:0] alarm_q;
  logic [31:0] stamp_q;
  rtcd_key_t   key_q;

  logic        wr_go;
  logic        rd_go;
  logic [31:0] rd_mux;
  logic [31:0] ctrl1_word;
  logic [31:0] status_word;
  logic        key_byte_ok;
  logic [7:0]  key_byte;

  rtcd_tick_if tk ();

  // ----------------------------------------------------------------------
  // byte lane merge
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        res[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------
  // every access sees one wait cycle; the write lands and read data are
  // valid on the edge where waitrequest is sampled low
  assign wr_go = avs_write & ~wait_q;
  assign rd_go = avs_read  & ~wait_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wait_q <= 1'b1;
    else if ((avs_read | avs_write) & wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  assign avs_waitrequest = wait_q;

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  assign ctrl1_word  = {16'h0000, enable_q, 3'h0, lock_q, ctrl1_rest_q};
  assign status_word = {28'h0000000, key_q == RTCD_KEY_ARMED,
                        key_q == RTCD_KEY_HALF, lock_q, tk.half_phase};

  // each value register has its own address, no pointer
  always_comb
  begin
    if (avs_address == `RTCD_OFS_CTRL1)
      rd_mux = ctrl1_word;
    else if (avs_address == `RTCD_OFS_CTRL2)
      rd_mux = {16'h0000, ctrl2_q};
    else if (avs_address == `RTCD_OFS_PERIOD)
      rd_mux = {16'h0000, period_q};
    else if (avs_address == `RTCD_OFS_STATUS)
      rd_mux = status_word;
    else if (avs_address == `RTCD_OFS_TIME)
      rd_mux = time_q;
    else if (avs_address == `RTCD_OFS_DATE)
      rd_mux = date_q;
    else if (avs_address == `RTCD_OFS_ALARM)
      rd_mux = alarm_q;
    else if (avs_address == `RTCD_OFS_STAMP)
      rd_mux = stamp_q;
    else
      rd_mux = 32'h00000000; // key and unmapped read as zero
  end

  // loaded one cycle early so data stand when waitrequest drops
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 32'h00000000;
    else if (avs_read & wait_q)
      rdata_q <= rd_mux;
  end

  assign avs_readdata = rdata_q;

  // ----------------------------------------------------------------------
  // unlock key sequence
  // ----------------------------------------------------------------------
  assign key_byte    = avs_writedata[7:0];
  assign key_byte_ok = (avs_address == `RTCD_OFS_KEY) & avs_byteenable[0];

  // any write breaks the pair; the armed state lives for one write only
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      key_q <= RTCD_KEY_IDLE;
    else if (wr_go)
    begin
      case (key_q)
        RTCD_KEY_HALF:
          if (key_byte_ok & (key_byte == `RTCD_KEY_SECOND))
            key_q <= RTCD_KEY_ARMED;
          else if (key_byte_ok & (key_byte == `RTCD_KEY_FIRST))
            key_q <= RTCD_KEY_HALF;
          else
            key_q <= RTCD_KEY_IDLE;
        default:
          if (key_byte_ok & (key_byte == `RTCD_KEY_FIRST))
            key_q <= RTCD_KEY_HALF;
          else
            key_q <= RTCD_KEY_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // control register one: enable and lock
  // ----------------------------------------------------------------------
  // asynchronous reset stands for every device reset source
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      lock_q <= 1'b0;
    else if (wr_go & (avs_address == `RTCD_OFS_CTRL1) & avs_byteenable[1])
    begin
      if (!lock_q)
        lock_q <= avs_writedata[`RTCD_LOCK_BIT];
      else if (!avs_writedata[`RTCD_LOCK_BIT] & (key_q == RTCD_KEY_ARMED))
        lock_q <= 1'b0;
    end
  end

  // enable is frozen by the lock value held before this write
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      enable_q <= 1'b0;
    else if (wr_go & (avs_address == `RTCD_OFS_CTRL1) & avs_byteenable[1]
             & ~lock_q)
      enable_q <= avs_writedata[`RTCD_EN_BIT];
  end

  // the rest of control one stays writable under lock
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl1_rest_q <= 11'h000;
    else if (wr_go & (avs_address == `RTCD_OFS_CTRL1))
      ctrl1_rest_q <= 11'(lane_merge(ctrl1_word, avs_writedata,
                                     avs_byteenable));
  end

  // ----------------------------------------------------------------------
  // locked registers: control two, period, time and date
  // ----------------------------------------------------------------------
  // blocked writes still complete on the bus with no error flag
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl2_q  <= 16'h0000;
      period_q <= `RTCD_PERIOD_RST;
      time_q   <= 32'h00000000;
      date_q   <= 32'h00000000;
    end
    else if (wr_go & ~lock_q)
    begin
      if (avs_address == `RTCD_OFS_CTRL2)
        ctrl2_q <= 16'(lane_merge({16'h0000, ctrl2_q}, avs_writedata,
                                  avs_byteenable)) & 16'hf833;
      else if (avs_address == `RTCD_OFS_PERIOD)
        period_q <= 16'(lane_merge({16'h0000, period_q}, avs_writedata,
                                   avs_byteenable));
      else if (avs_address == `RTCD_OFS_TIME)
        time_q <= lane_merge(time_q, avs_writedata, avs_byteenable);
      else if (avs_address == `RTCD_OFS_DATE)
        date_q <= lane_merge(date_q, avs_writedata, avs_byteenable);
    end
  end

  // ----------------------------------------------------------------------
  // unlocked registers: alarm and timestamp
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_q <= 32'h00000000;
      stamp_q <= 32'h00000000;
    end
    else if (wr_go)
    begin
      if (avs_address == `RTCD_OFS_ALARM)
        alarm_q <= lane_merge(alarm_q, avs_writedata, avs_byteenable);
      else if (avs_address == `RTCD_OFS_STAMP)
        stamp_q <= lane_merge(stamp_q, avs_writedata, avs_byteenable);
    end
  end

  // ----------------------------------------------------------------------
  // tick chain
  // ----------------------------------------------------------------------
  assign tk.source    = rtcd_src_t'(ctrl2_q[`RTCD_SRC_LSB +: 2]);
  assign tk.prescale  = ctrl2_q[`RTCD_PS_LSB +: 2];
  assign tk.fine_trim = ctrl2_q[`RTCD_TRIM_LSB +: 5];
  assign tk.period    = period_q;
  assign tk.run       = enable_q;

  rtcd_prescaler u_pre (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .crystal_in (secondary_crystal_osc),
    .rc_in      (low_power_rc_osc),
    .mains_in   (powerline_in),
    .tk         (tk)
  );

  rtcd_divider u_div (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tk    (tk)
  );

  // ----------------------------------------------------------------------
  // calendar side outputs
  // ----------------------------------------------------------------------
  assign half_tick             = tk.half_tick;
  assign sec_tick              = tk.sec_tick;
  assign calendar_clock_enable = enable_q;
  assign time_value            = time_q;
  assign date_value            = date_q;
  assign alarm_value           = alarm_q;

endmodule // rtcd_top

// ---- dv/rtcd_top_assertions.sv ----
/*
  Checker for the calendar clock front end: bus wait timing, read data
  hold, tick pairing and which bus writes may move enable, time and alarm.
  Assumes it is bound into rtcd_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`include "rtcd_cfg.svh"
module rtcd_top_assertions
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_n,
  // avalon-mm slave
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // calendar side
  input wire logic        half_tick,
  input wire logic        sec_tick,
  input wire logic        calendar_clock_enable,
  input wire logic [31:0] time_value,
  input wire logic [31:0] alarm_value
);
  logic ph_q; // expected half phase

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------------
  // helper
  // ----------------------------------------------------------------------
  // phase mirror; a late tick just after disable still toggles it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ph_q <= 1'b0;
    else if (half_tick)
      ph_q <= !ph_q;
    else if (!calendar_clock_enable)
      ph_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  a_wait_drop: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop after one wait cycle");
  a_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest stayed low for more than a cycle");
  a_wait_cause: assert property (
    !avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("waitrequest dropped with no request");
  a_rdata_hold: assert property (
    $changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("read data moved outside a read");
  a_enable_src: assert property (
    $changed(calendar_clock_enable) |-> $past(avs_write
      && !avs_waitrequest && avs_address == `RTCD_OFS_CTRL1))
    else $error("enable moved without a control write");
  a_time_src: assert property (
    $changed(time_value) |-> $past(avs_write && !avs_waitrequest
      && avs_address == `RTCD_OFS_TIME))
    else $error("time value moved without a time write");
  a_alarm_src: assert property (
    $changed(alarm_value) |-> $past(avs_write && !avs_waitrequest
      && avs_address == `RTCD_OFS_ALARM))
    else $error("alarm value moved without an alarm write");
  a_sec_in_half: assert property (
    sec_tick |-> half_tick)
    else $error("second tick without a half tick");
  a_sec_phase: assert property (
    half_tick && calendar_clock_enable && $past(calendar_clock_enable, 3)
      |-> sec_tick == ph_q)
    else $error("second tick not on every second half tick");
  a_no_tick_off: assert property (
    !calendar_clock_enable [*4] |-> !half_tick)
    else $error("half tick while divider disabled");
endmodule // rtcd_top_assertions

bind rtcd_top rtcd_top_assertions u_chk (
  .mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .half_tick, .sec_tick, .calendar_clock_enable,
  .time_value, .alarm_value
);

// ---- dv/tb_rtcd_top.sv ----
/*
  Self-checking bench for rtcd_top: reset values, tick spacing for each
  source and prescale and for trim 0, 1 and 31, and the write lock with its unlock key.
  Assumes the checker is bound in from its own file.
*/
`timescale 1ns/1ps
`include "rtcd_cfg.svh"
module tb_rtcd_top;
  typedef struct {logic [15:0] c2; logic [15:0] per; int n; int cyc;}
    rtcd_row_t;

  logic        mclk;
  logic        rst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  ref_q;
  logic        half_tick;
  logic        sec_tick;
  logic        calendar_clock_enable;
  logic [31:0] time_value;
  logic [31:0] date_value;
  logic [31:0] alarm_value;
  logic [31:0] rdata;
  int          error_cnt;
  int          comparisons;
  int          cyc;
  int          sec;
  rtcd_row_t   rows [11];

  rtcd_top u_dut (
    .mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .secondary_crystal_osc (ref_q[0]),
    .low_power_rc_osc      (ref_q[1]),
    .powerline_in          (ref_q[2]),
    .half_tick, .sec_tick, .calendar_clock_enable, .time_value,
    .date_value, .alarm_value
  );

  // ----------------------------------------------------------------------
  // clock, references, watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = !mclk;
  end

  // references rise every 2, 4 and 8 cycles so a wrong select shows
  always @(posedge mclk)
    ref_q <= ref_q + 3'h1;

  // the whole run needs under two thousand cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one transfer, held until waitrequest is seen low, then one idle edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50)
      chk(32'hdead, 32'h0);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  // cycles from the current half tick across n more of them
  task automatic span(input int n, output int c, output int s);
    c = 0;
    while (half_tick !== 1'b1 && c < 4000)
    begin
      @(posedge mclk);
      c++;
    end
    c = 0;
    s = 0;
    repeat (n)
    begin
      @(posedge mclk);
      c++;
      while (half_tick !== 1'b1 && c < 9000)
      begin
        @(posedge mclk);
        c++;
      end
      // second tick rides on every other half tick
      if (sec_tick === 1'b1)
        s++;
    end
  endtask

  task automatic check_resets();
    for (int a = 0; a <= 36; a += 4)
      rd_chk(8'(a), (a == 8) ? {16'h0, `RTCD_PERIOD_RST} : 32'h0);
    chk({31'h0, calendar_clock_enable}, 32'h0);
    chk(time_value | date_value | alarm_value, 32'h0);
  endtask

  task automatic stop_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    // source/prescale/trim word, period, intervals, expected cycles
    rows = '{'{16'h0003, 16'h1, 1, 2}, '{16'h0003, 16'h4, 1, 5},
             '{16'h0000, 16'h2, 1, 6}, '{16'h0001, 16'h1, 1, 8},
             '{16'h0002, 16'h0, 1, 8}, '{16'h0013, 16'h1, 1, 32},
             '{16'h0023, 16'h0, 1, 64}, '{16'h0033, 16'h0, 1, 256},
             '{16'h0003, 16'h1, 32, 64}, '{16'h0803, 16'h1, 32, 65},
             '{16'hf803, 16'h1, 32, 95}};
    rst_n = 1'b0;
    avs_address = 8'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    ref_q = 3'h0;
    error_cnt = 0;
    comparisons = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check_resets();
    // tick spacing per row; enable off between rows restarts the divider
    foreach (rows[i])
    begin
      wr(`RTCD_OFS_CTRL2, {16'h0, rows[i].c2});
      wr(`RTCD_OFS_PERIOD, {16'h0, rows[i].per});
      rd_chk(`RTCD_OFS_CTRL2, {16'h0, rows[i].c2});
      wr(`RTCD_OFS_CTRL1, 32'h8000);
      span(1, cyc, sec);
      span(rows[i].n, cyc, sec);
      chk(32'(cyc), 32'(rows[i].cyc));
      if (rows[i].n > 1)
        chk(32'(sec), 32'(rows[i].n / 2));
      wr(`RTCD_OFS_CTRL1, 32'h0);
    end
    wr(8'h24, 32'hffffffff);
    rd_chk(8'h24, 32'h0);
    rd_chk(`RTCD_OFS_KEY, 32'h0);
    // plain lock, then writes that must bounce
    wr(`RTCD_OFS_TIME, 32'ha5a55a5a);
    wr(`RTCD_OFS_DATE, 32'h11112222);
    wr(`RTCD_OFS_CTRL1, 32'h0800);
    rd_chk(`RTCD_OFS_STATUS, 32'h2);
    wr(`RTCD_OFS_CTRL1, 32'h8855);
    wr(`RTCD_OFS_CTRL2, 32'h0033);
    wr(`RTCD_OFS_PERIOD, 32'h0123);
    wr(`RTCD_OFS_TIME, 32'h0);
    wr(`RTCD_OFS_DATE, 32'h0);
    rd_chk(`RTCD_OFS_CTRL1, 32'h0855);
    rd_chk(`RTCD_OFS_CTRL2, 32'hf803);
    rd_chk(`RTCD_OFS_PERIOD, 32'h1);
    rd_chk(`RTCD_OFS_TIME, 32'ha5a55a5a);
    chk(date_value, 32'h11112222);
    chk({31'h0, calendar_clock_enable}, 32'h0);
    wr(`RTCD_OFS_ALARM, 32'hcafe0001);
    wr(`RTCD_OFS_STAMP, 32'h00000abc);
    chk(alarm_value, 32'hcafe0001);
    rd_chk(`RTCD_OFS_STAMP, 32'h00000abc);
    // clearing without, with broken and with late key
    wr(`RTCD_OFS_CTRL1, 32'h0);
    rd_chk(`RTCD_OFS_CTRL1, 32'h0800);
    wr(`RTCD_OFS_KEY, 32'h55);
    wr(`RTCD_OFS_KEY, 32'h12);
    wr(`RTCD_OFS_KEY, 32'haa);
    wr(`RTCD_OFS_CTRL1, 32'h0);
    rd_chk(`RTCD_OFS_CTRL1, 32'h0800);
    wr(`RTCD_OFS_KEY, 32'h55);
    wr(`RTCD_OFS_KEY, 32'haa);
    wr(`RTCD_OFS_ALARM, 32'hcafe0001);
    wr(`RTCD_OFS_CTRL1, 32'h0);
    rd_chk(`RTCD_OFS_CTRL1, 32'h0800);
    wr(`RTCD_OFS_KEY, 32'h55);
    wr(`RTCD_OFS_KEY, 32'haa);
    wr(`RTCD_OFS_CTRL1, 32'h8000);
    rd_chk(`RTCD_OFS_CTRL1, 32'h0);
    chk({31'h0, calendar_clock_enable}, 32'h0);
    wr(`RTCD_OFS_TIME, 32'h13);
    chk(time_value, 32'h13);
    // lock and enable sit in lane one; a lane-zero write leaves them
    avs_byteenable <= 4'h1;
    wr(`RTCD_OFS_CTRL1, 32'h8800);
    avs_byteenable <= 4'hf;
    rd_chk(`RTCD_OFS_CTRL1, 32'h0);
    // lock with enable, then a reset in mid-run
    wr(`RTCD_OFS_CTRL1, 32'h8800);
    chk({31'h0, calendar_clock_enable}, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check_resets();
    stop_test();
  end
endmodule // tb_rtcd_top
